// ### fcs_pkg.sv
package fcs_pkg;

	// Command codes written on the data bus.
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;

	// Status bit positions.
	localparam int SR_READY_BIT = 7;
	localparam int SR_PROG_ERR_BIT = 4;
	localparam int SR_SUPPLY_LOW_BIT = 3;
	localparam int SR_LOCKED_BIT = 1;

	// Strobe timing at 40 MHz.
	localparam int CLK_PERIOD_NS = 25;
	localparam int WE_LOW_NS = 70;
	localparam int WE_HIGH_NS = 30;
	localparam int READ_ACCESS_NS = 70;
	localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WE_HIGH_CYC =
		(WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_CYC =
		(READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 4;

	// Host operation requested by user logic.
	typedef enum logic [2:0] {
		FCS_OP_READ = 3'h0,
		FCS_OP_PROGRAM = 3'h1,
		FCS_OP_ERASE = 3'h2,
		FCS_OP_STATUS = 3'h3,
		FCS_OP_CLEAR = 3'h4,
		FCS_OP_ARRAY = 3'h5
	} fcs_op_t;

	// Request from user logic.
	typedef struct packed {
		fcs_op_t op;
		logic [21:0] addr;
		logic [15:0] data;
	} fcs_req_t;

	// Flash control pins, driven from flip-flops.
	typedef struct packed {
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic rp_n;
	} fcs_ctl_t;

	// Controller states, Gray coded from FCS_IDLE through FCS_WLOW and FCS_WHIGH to FCS_NEXT.
	typedef enum logic [2:0] {
		FCS_IDLE = 3'b000,
		FCS_WLOW = 3'b001,
		FCS_WHIGH = 3'b011,
		FCS_NEXT = 3'b010,
		FCS_RLOW = 3'b110,
		FCS_DONE = 3'b111
	} fcs_state_t;

endpackage

// ### fcs_host.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Write only while select and strobe low.
// - Host writes read-array before array reads; the code writes it only on an FCS_OP_ARRAY request and flags array_mode.
// - Tie flash reset to processor reset.
// - Hold flash reset during power transitions.
// - Read-array command is code FFH.
module fcs_host
	import fcs_pkg::*;
#(
	parameter int ADDR_W = 22,
	parameter int DATA_W = 16
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic reset_n,
	// User request and answer.
	input wire logic req_valid,
	input wire fcs_req_t req,
	output logic req_ready,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_data,
	output logic array_mode,
	// Flash pins.
	output fcs_ctl_t flash_ctl,
	output logic [ADDR_W-1:0] flash_addr,
	output logic [DATA_W-1:0] flash_dq_out,
	output logic flash_dq_oe,
	input wire logic [DATA_W-1:0] flash_dq_in
);

	fcs_state_t state_ff;
	fcs_req_t cur_ff;
	logic second_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic [DATA_W-1:0] dq_meta_ff;
	logic [DATA_W-1:0] dq_sync_ff;
	logic rst_sync_ff;

	// Command byte for the first write of each operation.
	function automatic logic [7:0] first_cmd(input fcs_op_t op);
		case (op)
			FCS_OP_PROGRAM: first_cmd = CMD_PROG_SETUP;
			FCS_OP_ERASE: first_cmd = CMD_ERASE_SETUP;
			FCS_OP_STATUS: first_cmd = CMD_READ_STATUS;
			FCS_OP_CLEAR: first_cmd = CMD_CLEAR_STATUS;
			default: first_cmd = CMD_READ_ARRAY;
		endcase
	endfunction

	// Operations that finish with a second write.
	function automatic logic two_cycle(input fcs_op_t op);
		two_cycle = (op == FCS_OP_PROGRAM) || (op == FCS_OP_ERASE);
	endfunction

	// Read data passes two flip-flops before use.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			dq_meta_ff <= '0;
			dq_sync_ff <= '0;
		end else begin
			dq_meta_ff <= flash_dq_in;
			dq_sync_ff <= dq_meta_ff;
		end
	end

	// Reset release is staged one flop ahead of the flash reset pin.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_ff <= 1'b0;
		end else begin
			rst_sync_ff <= 1'b1;
		end
	end

	// Main sequencer: strobes, counter and request capture.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= FCS_IDLE;
			cur_ff <= '0;
			second_ff <= 1'b0;
			cnt_ff <= '0;
			flash_ctl.ce_n <= 1'b1;
			flash_ctl.we_n <= 1'b1;
			flash_ctl.oe_n <= 1'b1;
			flash_ctl.rp_n <= 1'b0;
			flash_addr <= '0;
			flash_dq_out <= '0;
			flash_dq_oe <= 1'b0;
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= '0;
		end else begin
			flash_ctl.rp_n <= rst_sync_ff;
			rsp_valid <= 1'b0;
			case (state_ff)
				FCS_IDLE: begin
					req_ready <= flash_ctl.rp_n;
					if (req_valid && req_ready) begin
						req_ready <= 1'b0;
						cur_ff <= req;
						second_ff <= 1'b0;
						cnt_ff <= '0;
						flash_addr <= req.addr[ADDR_W-1:0];
						if (req.op == FCS_OP_READ) begin
							flash_ctl.ce_n <= 1'b0;
							flash_ctl.oe_n <= 1'b0;
							state_ff <= FCS_RLOW;
						end else begin
							flash_ctl.ce_n <= 1'b0;
							flash_ctl.we_n <= 1'b0;
							flash_dq_oe <= 1'b1;
							flash_dq_out <= {{(DATA_W-8){1'b0}},
								first_cmd(req.op)};
							state_ff <= FCS_WLOW;
						end
					end
				end
				FCS_WLOW: begin
					cnt_ff <= cnt_ff + 1'b1;
					if (cnt_ff == CNT_W'(WE_LOW_CYC - 1)) begin
						flash_ctl.we_n <= 1'b1;
						cnt_ff <= '0;
						state_ff <= FCS_WHIGH;
					end
				end
				FCS_WHIGH: begin
					flash_ctl.ce_n <= 1'b1;
					flash_dq_oe <= 1'b0;
					cnt_ff <= cnt_ff + 1'b1;
					if (cnt_ff == CNT_W'(WE_HIGH_CYC - 1)) begin
						cnt_ff <= '0;
						state_ff <= FCS_NEXT;
					end
				end
				FCS_NEXT: begin
					if (two_cycle(cur_ff.op) && !second_ff) begin
						second_ff <= 1'b1;
						flash_ctl.ce_n <= 1'b0;
						flash_ctl.we_n <= 1'b0;
						flash_dq_oe <= 1'b1;
						flash_dq_out <= (cur_ff.op == FCS_OP_ERASE) ?
							{{(DATA_W-8){1'b0}}, CMD_ERASE_CONFIRM} :
							cur_ff.data[DATA_W-1:0];
						state_ff <= FCS_WLOW;
					end else begin
						state_ff <= FCS_DONE;
					end
				end
				FCS_RLOW: begin
					cnt_ff <= cnt_ff + 1'b1;
					// Two extra cycles cover the input synchroniser.
					if (cnt_ff == CNT_W'(READ_CYC + 1)) begin
						rsp_data <= dq_sync_ff;
						flash_ctl.ce_n <= 1'b1;
						flash_ctl.oe_n <= 1'b1;
						state_ff <= FCS_DONE;
					end
				end
				default: begin
					rsp_valid <= 1'b1;
					state_ff <= FCS_IDLE;
				end
			endcase
		end
	end

	// array reads follow a read-array write.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			array_mode <= 1'b1;
		end else if (state_ff == FCS_IDLE && req_valid && req_ready &&
				req.op != FCS_OP_READ) begin
			array_mode <= (req.op == FCS_OP_ARRAY);
		end
	end

	a_we_needs_ce: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!flash_ctl.we_n |-> !flash_ctl.ce_n)
		else $error("Write strobe low while select high.");

	a_we_first: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$rose(flash_ctl.we_n) |-> !flash_ctl.ce_n ##1 flash_ctl.ce_n)
		else $error("Select did not follow strobe.");

	// two writes for program or erase.
	a_two_writes: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(state_ff == FCS_NEXT && two_cycle(cur_ff.op) && !second_ff)
		|=> $fell(flash_ctl.we_n))
		else $error("Second command write missing.");

	// flash reset low while host reset recent.
	a_rp_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$rose(flash_ctl.rp_n) |-> $past(rst_sync_ff))
		else $error("Flash reset released early.");

	// no strobes while flash in reset.
	a_rp_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!flash_ctl.rp_n |-> flash_ctl.we_n && !req_ready)
		else $error("Activity while flash reset low.");

	a_array_code: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(state_ff == FCS_IDLE && req_valid && req_ready &&
		req.op == FCS_OP_ARRAY) |=> array_mode ##0
		flash_dq_out[7:0] == CMD_READ_ARRAY)
		else $error("Read-array code wrong.");

	a_prog_leaves: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(state_ff == FCS_IDLE && req_valid && req_ready &&
		req.op == FCS_OP_PROGRAM) |=> !array_mode)
		else $error("Array mode kept after program.");

	// Strobe low width in cycles.
	a_we_width: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$fell(flash_ctl.we_n) |-> !flash_ctl.we_n [*3] ##1
		flash_ctl.we_n)
		else $error("Write strobe width wrong.");

	c_program: cover property (@(posedge ref_clk) disable iff (!reset_n)
		state_ff == FCS_NEXT && second_ff && cur_ff.op == FCS_OP_PROGRAM);
	c_erase: cover property (@(posedge ref_clk) disable iff (!reset_n)
		state_ff == FCS_NEXT && second_ff && cur_ff.op == FCS_OP_ERASE);
	c_read: cover property (@(posedge ref_clk) disable iff (!reset_n)
		state_ff == FCS_RLOW ##[1:10] rsp_valid);

endmodule

// ### fcs_flash_model.sv
`timescale 1ns/10ps
module fcs_flash_model
	import fcs_pkg::*;
(
	// Flash pins.
	input wire fcs_ctl_t ctl,
	input wire logic [21:0] addr,
	input wire logic [15:0] dq_in,
	output logic [15:0] dq_out
);
	logic [15:0] mem [16];
	logic [15:0] lock_bits;
	logic [127:0] prot_reg;
	logic err_locked;
	logic [15:0] status;
	logic [7:0] pend;
	logic stat_mode;
	logic [15:0] last;
	logic [15:0] rd;
	wire wr_end = ctl.ce_n | ctl.we_n;

	// Array starts with a known pattern and the top block locked.
	// protection register: 128 bits of security data.
	initial begin
		foreach (mem[i]) mem[i] = 16'h0F0F;
		lock_bits = 16'h8000;
		prot_reg = '1;
		err_locked = 1'b0;
	end

	// sticky error: status shows ready plus the lock error.
	always_comb begin
		status = '0;
		status[SR_READY_BIT] = 1'b1;
		status[SR_LOCKED_BIT] = err_locked;
	end

	// capture: a write lands as select or strobe rises.
	// reset state: a low reset pin forces array reads.
	always @(posedge wr_end or negedge ctl.rp_n) begin
		if (!ctl.rp_n) begin
			stat_mode <= 1'b0;
			pend <= 8'h00;
		// alteration: only a setup then its data.
		end else if (pend != 8'h00) begin
			// lock applies at once: a locked block refuses change.
			if (pend == CMD_PROG_SETUP) begin
				if (lock_bits[addr[3:0]])
					err_locked <= 1'b1;
				else
					mem[addr[3:0]] <= mem[addr[3:0]] & dq_in;
			end else if (dq_in[7:0] == CMD_ERASE_CONFIRM) begin
				foreach (mem[i])
					if (!lock_bits[i])
						mem[i] <= 16'hFFFF;
			end
			pend <= 8'h00;
			stat_mode <= 1'b1;
		end else begin
			if (dq_in[7:0] == CMD_PROG_SETUP || dq_in[7:0] == CMD_ERASE_SETUP)
				pend <= dq_in[7:0];
			if (dq_in[7:0] == CMD_CLEAR_STATUS)
				err_locked <= 1'b0;
			if (dq_in[7:0] == CMD_READ_ARRAY)
				stat_mode <= 1'b0;
			else if (dq_in[7:0] != CMD_CLEAR_STATUS)
				stat_mode <= 1'b1;
		end
	end

	// Released bus shows the inverse of the last value read.
	assign rd = stat_mode ? status : mem[addr[3:0]];
	always @(posedge ctl.oe_n) last <= rd;
	assign dq_out = (ctl.ce_n | ctl.oe_n | !ctl.rp_n) ? ~last : rd;
endmodule

// ### tb_top.sv
`timescale 1ns/10ps
module tb_top
	import fcs_pkg::*;
;
	logic ref_clk, reset_n, req_valid, req_ready, rsp_valid, array_mode;
	fcs_req_t req;
	fcs_ctl_t flash_ctl;
	logic [21:0] flash_addr;
	logic [15:0] rsp_data, flash_dq_out, model_dq, dq_bus;
	logic flash_dq_oe;
	int bad_count, checks;

	// The bus carries whichever party drives it.
	assign dq_bus = flash_dq_oe ? flash_dq_out : model_dq;

	fcs_host fcs_host_inst (.ref_clk(ref_clk), .reset_n(reset_n),
		.req_valid(req_valid), .req(req), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .array_mode(array_mode),
		.flash_ctl(flash_ctl), .flash_addr(flash_addr),
		.flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
		.flash_dq_in(dq_bus));
	fcs_flash_model fcs_flash_model_inst (.ctl(flash_ctl),
		.addr(flash_addr), .dq_in(dq_bus), .dq_out(model_dq));

	// Clock at 40 MHz.
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic chk(input string name, input logic [15:0] e, g);
		checks++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", name, e, g);
			bad_count++;
		end
	endtask

	task automatic stop_test();
		$display("mismatches %0d checks %0d", bad_count, checks);
		if (bad_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic do_reset();
		@(posedge ref_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk("rp_n in reset", 16'h0000, flash_ctl.rp_n);
		reset_n <= 1'b1;
	endtask

	// One request, held until taken, then wait for its answer.
	task automatic run_op(input fcs_op_t op, input logic [21:0] a,
		input logic [15:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req <= '{op: op, addr: a, data: d};
		do @(negedge ref_clk); while (!req_ready && ++n < 60);
		@(posedge ref_clk);
		req_valid <= 1'b0;
		do @(negedge ref_clk); while (rsp_valid !== 1'b1 && ++n < 120);
		chk("answer", 16'h0001, rsp_valid);
	endtask

	task automatic t_program();
		run_op(FCS_OP_PROGRAM, 22'h000003, 16'h1234);
		chk("array_mode", 16'h0000, array_mode);
		run_op(FCS_OP_READ, 22'h000003, 16'h0000);
		chk("status", 16'h0080, rsp_data);
		run_op(FCS_OP_ARRAY, 22'h000000, 16'h0000);
		chk("array_mode", 16'h0001, array_mode);
		run_op(FCS_OP_READ, 22'h000003, 16'h0000);
		chk("programmed", 16'h0F0F & 16'h1234, rsp_data);
	endtask

	task automatic t_erase();
		run_op(FCS_OP_CLEAR, 22'h000005, 16'h0000);
		run_op(FCS_OP_ARRAY, 22'h000000, 16'h0000);
		run_op(FCS_OP_READ, 22'h000005, 16'h0000);
		chk("lone write", 16'h0F0F, rsp_data);
		run_op(FCS_OP_ERASE, 22'h000005, 16'h0000);
		run_op(FCS_OP_STATUS, 22'h000000, 16'h0000);
		run_op(FCS_OP_ARRAY, 22'h000000, 16'h0000);
		run_op(FCS_OP_READ, 22'h000005, 16'h0000);
		chk("erased", 16'hFFFF, rsp_data);
	endtask

	// A program into the locked top block sets a sticky error.
	task automatic t_locked();
		run_op(FCS_OP_PROGRAM, 22'h00000F, 16'h0000);
		run_op(FCS_OP_READ, 22'h00000F, 16'h0000);
		chk("locked error", 16'h0082, rsp_data);
		run_op(FCS_OP_ARRAY, 22'h000000, 16'h0000);
		run_op(FCS_OP_READ, 22'h00000F, 16'h0000);
		chk("locked data", 16'h0F0F, rsp_data);
		run_op(FCS_OP_STATUS, 22'h000000, 16'h0000);
		run_op(FCS_OP_READ, 22'h000000, 16'h0000);
		chk("error kept", 16'h0082, rsp_data);
		run_op(FCS_OP_CLEAR, 22'h000000, 16'h0000);
		run_op(FCS_OP_READ, 22'h000000, 16'h0000);
		chk("error cleared", 16'h0080, rsp_data);
	endtask

	task automatic t_restart();
		run_op(FCS_OP_STATUS, 22'h000000, 16'h0000);
		do_reset();
		chk("array_mode", 16'h0001, array_mode);
		run_op(FCS_OP_READ, 22'h000003, 16'h0000);
		chk("after reset", 16'hFFFF, rsp_data);
	endtask

	// Main sequence.
	initial begin
		reset_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		bad_count = 0;
		checks = 0;
		do_reset();
		chk("array_mode", 16'h0001, array_mode);
		t_program();
		t_erase();
		t_locked();
		t_restart();
		stop_test();
	end

	// Watchdog well beyond the expected run.
	initial begin
		#100000;
		bad_count++;
		stop_test();
	end
endmodule
